//--- hdl/tslave_consts.svh
// Offsets, fields, reset values and codes of the timer slave-mode block
// Assumes a 32-bit Avalon-MM slave with byte addresses
`ifndef TSLAVE_CONSTS_SVH
`define TSLAVE_CONSTS_SVH
`define OFF_CTRL 6'h00
`define OFF_SMCR 6'h04
`define OFF_CCER 6'h08
`define OFF_CCMR 6'h0C
`define OFF_ARR 6'h10
`define OFF_CCR 6'h14
`define OFF_CNT 6'h18
`define OFF_STAT 6'h1C
`define OFF_PSC 6'h20
`define OFF_IEN 6'h24
`define CTRL_CEN 0
`define CTRL_URS 1
`define CTRL_DIR 2
`define CTRL_XSEL 3
`define CTRL_UG 4
`define SMCR_SMS 2:0
`define SMCR_TS 6:4
`define CCER_CC1P 0
`define CCER_CC2P 1
`define CCMR_CC1S 1:0
`define CCMR_IC1F 7:4
`define CCMR_CC2S 9:8
`define CCMR_IC2F 15:12
`define FLG_TIF 0
`define FLG_UIF 1
`define FLG_CCIF 2
`define IEN_TIE 0
`define ARR_RST 16'hFFFF
`define TS_FIRST 3'h5
`define CCS_OWN 2'h1
`define FILT_OFF 4'h0
`endif

//--- hdl/tslave_pkg.sv
// Types of the timer slave-mode block
// Assumes the constants header is on the include path
package tslave_pkg;
    typedef enum logic [2:0] {
        SM_OFF = 3'h0,
        SM_ENC2 = 3'h1,
        SM_ENC1 = 3'h2,
        SM_ENC12 = 3'h3,
        SM_RESET = 3'h4,
        SM_GATED = 3'h5
    } smode_t;

    typedef struct packed {
        logic wr;
        logic [31:0] rdata;
        logic cen;
        logic urs;
        logic xsel;
        logic dir;
        logic [2:0] sms;
        logic [2:0] ts;
        logic cc1p;
        logic cc2p;
        logic [1:0] cc1s;
        logic [1:0] cc2s;
        logic [3:0] ic1f;
        logic [3:0] ic2f;
        logic tie;
        logic [15:0] arr_buf;
        logic [15:0] arr;
        logic [15:0] ccr_buf;
        logic [15:0] ccr;
        logic [15:0] psc;
        logic [15:0] pcnt;
        logic [15:0] cnt;
        logic [2:0] flags;
        logic irq;
        logic [3:0] s1;
        logic [3:0] s2;
        logic f1;
        logic f2;
        logic [3:0] fc1;
        logic [3:0] fc2;
        logic p1;
        logic p2;
        logic trg_prev;
        logic gate_prev;
    } st_t;
endpackage

//--- hdl/tslave.sv
// Timer slave-mode control: encoder counting, reset mode, gated mode
// Assumes an Avalon-MM master on mclk and asynchronous channel pins
//
// How it works
// RQ1 - Mode code picks which encoder edges count
// RQ2 - Polarity and filter applied before encoder evaluation
// RQ3 - Enabled counter steps per counted valid transition
// RQ4 - Direction recomputed on any encoder input transition; the code recomputes it only when exactly one input changes
// RQ5 - Counter wraps between zero and reload value
// RQ6 - Prescaler and compare keep working under encoder
// RQ7 - First-input edge direction set by second input
// RQ8 - Second-input edge direction set by first; uncounted ignored
// RQ9 - XOR of pins two to four feeds channel one
// RQ10 - Reset trigger reinitializes; update unless source bit set
// RQ11 - Trigger select 101 routes first filtered input
// RQ12 - Reset mode clears counter, sets trigger flag
// RQ13 - Trigger inputs resynchronized to the timer clock
// RQ14 - Gated mode counts only while trigger active
// RQ15 - Gated mode never counts with enable clear
// RQ16 - Gated mode flags both start and stop
// RQ17 - Polarity one makes low level active
// RQ18 - Capture select 01 maps input to own pin
// RQ19 - Filter code zero passes input unfiltered
// RQ20 - Simultaneous input changes give no count, keep direction
`timescale 1ns/1ps
`default_nettype none
`include "tslave_consts.svh"

module tslave
    import tslave_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic chan1_pin,
    input wire logic channel2_pin,
    input wire logic chan3_pin,
    input wire logic channel4_pin,
    output logic trigger_flag,
    output logic trig_irq,
    output logic count_direction_bit
);

    ////////////////////////////////////////////////////////////////////
    // Digital filter step: returns {output, run counter}
    function automatic logic [4:0] filt(input logic raw, input logic cur,
                                        input logic [3:0] c, input logic [3:0] len);
        logic [4:0] r;
        r = {cur, 4'h0};
        if (len == `FILT_OFF) begin
            r = {raw, 4'h0}; // RQ19
        end else if (raw != cur) begin
            if (c + 4'h1 >= len) begin
                r = {raw, 4'h0};
            end else begin
                r = {cur, c + 4'h1};
            end
        end
        return r;
    endfunction

    st_t q;
    st_t n;
    logic ti1, ti2, fp1, fp2, e1, e2;
    logic enc, cnt1, cnt2, enc_pulse;
    logic trgi, trg_edge, gate, src, step, upd, rst_trg, bus_wr;
    logic [2:0] fset;
    logic [15:0] wlo;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = q;
        fset = 3'h0;
        upd = 1'b0;
        step = 1'b0;
        wlo = writedata[15:0];
        bus_wr = write && !q.wr;

        // Two-stage pin resynchronizer
        n.s1 = {channel4_pin, chan3_pin, channel2_pin, chan1_pin}; // RQ13
        n.s2 = q.s1;

        // Channel 1 source: own pin or XOR of pins two to four
        ti1 = q.xsel ? (q.s2[1] ^ q.s2[2] ^ q.s2[3]) : q.s2[0]; // RQ9
        ti2 = q.s2[1];
        {n.f1, n.fc1} = filt(ti1, q.f1, q.fc1, q.ic1f); // RQ2
        {n.f2, n.fc2} = filt(ti2, q.f2, q.fc2, q.ic2f);

        // Polarity-adjusted inputs, mapped only on own pin
        fp1 = (q.cc1s == `CCS_OWN) ? (q.f1 ^ q.cc1p) : 1'b0; // RQ18 RQ17
        fp2 = (q.cc2s == `CCS_OWN) ? (q.f2 ^ q.cc2p) : 1'b0; // RQ2
        n.p1 = fp1;
        n.p2 = fp2;
        e1 = fp1 != q.p1;
        e2 = fp2 != q.p2;

        // Encoder mode decode
        enc = (q.sms == SM_ENC1) || (q.sms == SM_ENC2) || (q.sms == SM_ENC12); // RQ1
        cnt1 = (q.sms == SM_ENC1) || (q.sms == SM_ENC12);
        cnt2 = (q.sms == SM_ENC2) || (q.sms == SM_ENC12);

        // Direction from sequence, only for a lone edge
        if (enc && (e1 ^ e2)) begin // RQ4 RQ20
            if (e1) begin
                n.dir = !(fp1 ^ fp2); // RQ7
            end else begin
                n.dir = fp1 ^ fp2; // RQ8
            end
        end
        enc_pulse = q.cen && enc && ((e1 && !e2 && cnt1) || (e2 && !e1 && cnt2)); // RQ3 RQ8

        // Trigger input and its edge
        trgi = (q.ts == `TS_FIRST) ? fp1 : 1'b0; // RQ11
        trg_edge = trgi && !q.trg_prev;
        n.trg_prev = trgi;
        gate = q.cen && trgi && (q.sms == SM_GATED); // RQ15 RQ14
        n.gate_prev = gate;
        if ((q.sms == SM_GATED) && (gate != q.gate_prev)) begin
            fset[`FLG_TIF] = 1'b1; // RQ16
        end

        // Count clock source
        if (enc) begin
            src = enc_pulse;
        end else if (q.sms == SM_GATED) begin
            src = gate;
        end else begin
            src = q.cen;
        end

        // Prescaler
        if (src) begin // RQ6
            if (q.pcnt >= q.psc) begin
                n.pcnt = 16'h0000;
                step = 1'b1;
            end else begin
                n.pcnt = q.pcnt + 16'h0001;
            end
        end

        // Counter with wrap at zero and reload value
        if (step) begin
            if (n.dir) begin
                if (q.cnt == 16'h0000) begin
                    n.cnt = q.arr; // RQ5
                    upd = 1'b1;
                end else begin
                    n.cnt = q.cnt - 16'h0001;
                end
            end else if (q.cnt >= q.arr) begin
                n.cnt = 16'h0000; // RQ5
                upd = 1'b1;
            end else begin
                n.cnt = q.cnt + 16'h0001;
            end
            if (n.cnt == q.ccr) begin
                fset[`FLG_CCIF] = 1'b1; // RQ6
            end
        end

        // Reset mode trigger
        rst_trg = (q.sms == SM_RESET) && trg_edge;
        if (rst_trg) begin
            n.cnt = 16'h0000; // RQ10 RQ12
            n.pcnt = 16'h0000;
            fset[`FLG_TIF] = 1'b1; // RQ12
            upd = !q.urs; // RQ10
        end

        // Software-generated update
        if (bus_wr && (address == `OFF_CTRL) && writedata[`CTRL_UG]) begin
            n.cnt = 16'h0000;
            n.pcnt = 16'h0000;
            upd = 1'b1;
        end

        // Update event loads buffered values
        if (upd) begin
            n.arr = q.arr_buf; // RQ10
            n.ccr = q.ccr_buf;
            fset[`FLG_UIF] = 1'b1;
        end

        // Register writes
        n.flags = q.flags | fset;
        if (bus_wr) begin
            unique case (address)
                `OFF_CTRL: begin
                    n.cen = writedata[`CTRL_CEN];
                    n.urs = writedata[`CTRL_URS];
                    n.xsel = writedata[`CTRL_XSEL];
                    if (!enc) begin
                        n.dir = writedata[`CTRL_DIR];
                    end
                end
                `OFF_SMCR: begin
                    n.sms = writedata[`SMCR_SMS];
                    n.ts = writedata[`SMCR_TS];
                end
                `OFF_CCER: begin
                    n.cc1p = writedata[`CCER_CC1P];
                    n.cc2p = writedata[`CCER_CC2P];
                end
                `OFF_CCMR: begin
                    n.cc1s = writedata[`CCMR_CC1S];
                    n.ic1f = writedata[`CCMR_IC1F];
                    n.cc2s = writedata[`CCMR_CC2S];
                    n.ic2f = writedata[`CCMR_IC2F];
                end
                `OFF_ARR: n.arr_buf = wlo; // RQ5
                `OFF_CCR: n.ccr_buf = wlo;
                `OFF_CNT: n.cnt = wlo;
                `OFF_STAT: n.flags = (q.flags & ~writedata[2:0]) | fset;
                `OFF_PSC: n.psc = wlo;
                `OFF_IEN: n.tie = writedata[`IEN_TIE];
                default: ;
            endcase
        end
        n.irq = n.flags[`FLG_TIF] && n.tie; // RQ12

        // Bus handshake: one wait cycle, then answer
        if ((read || write) && q.wr) begin
            n.wr = 1'b0;
            unique case (address)
                `OFF_CTRL: n.rdata = {27'h0, 1'b0, q.xsel, q.dir, q.urs, q.cen};
                `OFF_SMCR: n.rdata = {25'h0, q.ts, 1'b0, q.sms};
                `OFF_CCER: n.rdata = {30'h0, q.cc2p, q.cc1p};
                `OFF_CCMR: n.rdata = {16'h0, q.ic2f, 2'h0, q.cc2s, q.ic1f, 2'h0, q.cc1s};
                `OFF_ARR: n.rdata = {16'h0, q.arr_buf};
                `OFF_CCR: n.rdata = {16'h0, q.ccr_buf};
                `OFF_CNT: n.rdata = {16'h0, q.cnt};
                `OFF_STAT: n.rdata = {29'h0, q.flags};
                `OFF_PSC: n.rdata = {16'h0, q.psc};
                `OFF_IEN: n.rdata = {31'h0, q.tie};
                default: n.rdata = 32'h0000_0000;
            endcase
        end else begin
            n.wr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            q <= '0;
            q.wr <= 1'b1;
            q.arr <= `ARR_RST;
            q.arr_buf <= `ARR_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from state
    assign readdata = q.rdata;
    assign waitrequest = q.wr;
    assign trigger_flag = q.flags[`FLG_TIF];
    assign trig_irq = q.irq;
    assign count_direction_bit = q.dir;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_both_edges_hold: assert property (enc && e1 && e2 && !bus_wr |=> $stable(q.dir) && $stable(q.pcnt)) // RQ20
        else $error("simultaneous edges changed state");
    a_first_edge_dir: assert property (enc && e1 && !e2 |=> q.dir == !($past(fp1) ^ $past(fp2))) // RQ7
        else $error("first input direction wrong");
    a_uncounted_edge: assert property ((q.sms == SM_ENC2) && e1 && !e2 && !bus_wr && !rst_trg
        |=> $stable(q.cnt) && $stable(q.pcnt)) // RQ8
        else $error("uncounted edge changed counter");
    a_wrap_up_zero: assert property (step && !n.dir && (q.cnt >= q.arr) && !bus_wr && !rst_trg |=> q.cnt == 16'h0000) // RQ5
        else $error("up wrap not to zero");
    a_reset_trigger: assert property (rst_trg && !bus_wr |=> (q.cnt == 16'h0000) && q.flags[`FLG_TIF]) // RQ12
        else $error("reset trigger missed");
    a_reset_update: assert property (rst_trg && !q.urs && !bus_wr |=> q.arr == $past(q.arr_buf)) // RQ10
        else $error("reset trigger update missed");
    a_gate_off_hold: assert property ((q.sms == SM_GATED) && !q.cen && !bus_wr ##1 !bus_wr |=> $stable(q.cnt)) // RQ15
        else $error("gated counter ran while disabled");
    a_gate_edge_flag: assert property ((q.sms == SM_GATED) && (gate != q.gate_prev) |=> q.flags[`FLG_TIF]) // RQ16
        else $error("gate change did not set flag");
    a_nofilter_pass: assert property ((q.ic1f == `FILT_OFF) && !q.xsel |=> q.f1 == $past(q.s2[0])) // RQ19
        else $error("unfiltered path delayed");
    a_bus_answer: assert property ((read || write) && q.wr |=> !q.wr ##1 q.wr)
        else $error("bus answer timing wrong");

endmodule
`default_nettype wire

//--- sim/quad_encoder.sv
// Quadrature encoder model driving the first and second channel pins
// Assumes the caller runs one task at a time, on the timer clock
`timescale 1ns/1ps
`default_nettype none
module quad_encoder (
    input wire logic clk,
    output var logic enc_a,
    output var logic enc_b
);
    logic [1:0] phase = 2'h0;
    // Lines idle low
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
    end
    // One Gray step: one line changes, then a settle gap
    task automatic step(input logic fwd);
        @(posedge clk);
        phase = fwd ? phase + 2'h1 : phase - 2'h1;
        enc_a <= phase[1] ^ phase[0];
        enc_b <= phase[1];
        repeat (8) @(posedge clk);
    endtask
    // Set both lines to given levels
    task automatic put(input logic a, input logic b);
        @(posedge clk);
        phase = {b, a ^ b};
        enc_a <= a;
        enc_b <= b;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- sim/tb_timer_encoder_slave_modes.sv
// Self-checking bench of the timer slave-mode block
// Assumes tslave, quad_encoder and the constants header
`timescale 1ns/1ps
`default_nettype none
`include "tslave_consts.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module tb_timer_encoder_slave_modes;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic chan3_pin = 1'b0;
    logic channel4_pin = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic trigger_flag;
    logic trig_irq;
    logic count_direction_bit;
    logic enc_a;
    logic enc_b;
    logic [31:0] rv;
    logic [15:0] held;
    int err_count = 0;
    int compares = 0;
    // Clock
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    tslave i_dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .chan1_pin(enc_a), .channel2_pin(enc_b), .chan3_pin(chan3_pin),
        .channel4_pin(channel4_pin), .trigger_flag(trigger_flag), .trig_irq(trig_irq),
        .count_direction_bit(count_direction_bit));
    quad_encoder i_enc (.clk(mclk), .enc_a(enc_a), .enc_b(enc_b));
    ////////////////////////////////////////////////////////////////
    // Bus write, held until waitrequest low
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge mclk);
    endtask
    // Bus read, data taken at the low-wait edge
    task automatic rd(input logic [5:0] a);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rv = readdata;
        read <= 1'b0;
        @(posedge mclk);
    endtask
    // Counter read and compare
    task automatic chk_cnt(input string n, input logic [15:0] e);
        rd(`OFF_CNT);
        `CHK(n, e, rv[15:0])
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset values and unmapped place
    task automatic t_regs();
        rd(`OFF_ARR);
        `CHK("arr_rst", 32'h0000FFFF, rv)
        rd(6'h3C);
        `CHK("unmapped", 32'h0, rv)
        $display("test regs done");
    endtask
    // Both inputs counted, wrap both ways
    task automatic t_enc_both();
        wr(`OFF_CCMR, 32'h0101);
        wr(`OFF_ARR, 32'h3);
        wr(`OFF_SMCR, 32'h3);
        wr(`OFF_CTRL, 32'h11);
        repeat (5) i_enc.step(1'b1);
        chk_cnt("cnt_up_wrap", 16'h1);
        `CHK("dir_up", 1'b0, count_direction_bit)
        repeat (2) i_enc.step(1'b0);
        chk_cnt("cnt_down_wrap", 16'h3);
        `CHK("dir_down", 1'b1, count_direction_bit)
        $display("test encoder both done");
    endtask
    // One input counted, other input steers direction only
    task automatic t_enc_single();
        for (int m = 2; m >= 1; m--) begin
            wr(`OFF_SMCR, m);
            wr(`OFF_CNT, 32'h0);
            repeat (4) i_enc.step(1'b1);
            chk_cnt("cnt_single", 16'h2);
        end
        i_enc.step(1'b0);
        chk_cnt("cnt_uncounted", 16'h2);
        `CHK("dir_any_edge", 1'b1, count_direction_bit)
        i_enc.step(1'b1);
        i_enc.put(1'b1, 1'b0);
        chk_cnt("cnt_both_change", 16'h2);
        `CHK("dir_both_change", 1'b0, count_direction_bit)
        i_enc.put(1'b0, 1'b1);
        $display("test encoder single done");
    endtask
    // Inverted first input reverses counting
    task automatic t_pol();
        wr(`OFF_SMCR, 32'h3);
        wr(`OFF_CCER, 32'h1);
        repeat (8) @(posedge mclk);
        wr(`OFF_CNT, 32'h0);
        repeat (2) i_enc.step(1'b1);
        chk_cnt("cnt_inverted", 16'h2);
        `CHK("dir_inverted", 1'b1, count_direction_bit)
        $display("test polarity done");
    endtask
    // Prescaler and compare flag under encoder counting
    task automatic t_presc();
        wr(`OFF_PSC, 32'h1);
        wr(`OFF_CCR, 32'h2);
        wr(`OFF_CTRL, 32'h11);
        wr(`OFF_STAT, 32'h7);
        repeat (4) i_enc.step(1'b1);
        chk_cnt("cnt_prescaled", 16'h2);
        rd(`OFF_STAT);
        `CHK("cmp_flag", 1'b1, rv[`FLG_CCIF])
        wr(`OFF_PSC, 32'h0);
        $display("test prescaler done");
    endtask
    // Reset mode on first input rising edge
    task automatic t_reset();
        wr(`OFF_CCER, 32'h0);
        i_enc.put(1'b0, 1'b0);
        wr(`OFF_SMCR, 32'h54);
        wr(`OFF_ARR, 32'hFF);
        wr(`OFF_IEN, 32'h1);
        wr(`OFF_CTRL, 32'h11);
        wr(`OFF_STAT, 32'h7);
        repeat (20) @(posedge mclk);
        rd(`OFF_CNT);
        `CHK("running", 1'b1, rv[15:0] > 16'hF)
        i_enc.put(1'b1, 1'b0);
        rd(`OFF_CNT);
        `CHK("cleared", 1'b1, rv[15:0] < 16'h10)
        `CHK("trig_flag", 1'b1, trigger_flag)
        `CHK("trig_irq", 1'b1, trig_irq)
        rd(`OFF_STAT);
        `CHK("update_flag", 1'b1, rv[1])
        $display("test reset mode done");
    endtask
    // Gated mode, active low, start and stop flags
    task automatic t_gated();
        wr(`OFF_SMCR, 32'h55);
        wr(`OFF_CCER, 32'h1);
        repeat (8) @(posedge mclk);
        wr(`OFF_CNT, 32'h0);
        wr(`OFF_STAT, 32'h7);
        repeat (10) @(posedge mclk);
        chk_cnt("gate_closed", 16'h0);
        i_enc.put(1'b0, 1'b0);
        rd(`OFF_CNT);
        `CHK("gate_open", 1'b1, rv[15:0] > 16'h0)
        `CHK("flag_start", 1'b1, trigger_flag)
        wr(`OFF_STAT, 32'h1);
        i_enc.put(1'b1, 1'b0);
        `CHK("flag_stop", 1'b1, trigger_flag)
        rd(`OFF_CNT);
        held = rv[15:0];
        repeat (10) @(posedge mclk);
        chk_cnt("gate_held", held);
        wr(`OFF_CTRL, 32'h0);
        wr(`OFF_CNT, 32'h0);
        i_enc.put(1'b0, 1'b0);
        chk_cnt("cen_off", 16'h0);
        $display("test gated mode done");
    endtask
    // XOR of pins two to four as trigger
    task automatic t_xor();
        wr(`OFF_SMCR, 32'h54);
        wr(`OFF_CCER, 32'h0);
        wr(`OFF_CTRL, 32'h9);
        repeat (10) @(posedge mclk);
        wr(`OFF_STAT, 32'h1);
        chan3_pin <= ~chan3_pin;
        repeat (8) @(posedge mclk);
        `CHK("xor_flag_pin3", 1'b1, trigger_flag)
        wr(`OFF_STAT, 32'h1);
        i_enc.put(1'b0, 1'b1);
        `CHK("xor_fall_pin2", 1'b0, trigger_flag)
        channel4_pin <= ~channel4_pin;
        repeat (8) @(posedge mclk);
        `CHK("xor_flag_pin4", 1'b1, trigger_flag)
        rd(`OFF_CNT);
        `CHK("xor_reset", 1'b1, rv[15:0] < 16'h10)
        $display("test xor input done");
    endtask
    ////////////////////////////////////////////////////////////////
    // Counts and verdict
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_enc_both();
        t_enc_single();
        t_pol();
        t_presc();
        t_reset();
        t_gated();
        t_xor();
        print_verdict();
    end
    // Watchdog
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
